// File: hw/mspd_params.svh
// Constants for the memory space pager and decoder
`ifndef MSPD_PARAMS_SVH
`define MSPD_PARAMS_SVH
`define MSPD_DECREMENT_POINTER_INSTR_OP  8'ha5
`define MSPD_XRAM_TOP     16'h1fff
`define MSPD_SFR_BASE     8'h80
`define MSPD_CODE_A17     1'b1
`define MSPD_PG_RST       1'b0
`define MSPD_LT_RST       2'h0
`define MSPD_DATA_POINTER_RST     16'h0000
`define MSPD_XEN_RST      1'b0
`define MSPD_DATA_POINTER_STEP    16'h0001
`endif

// File: hw/mspd_pkg.sv
// Types shared by the memory space pager and decoder
package mspd_pkg;
    typedef enum logic [1:0] {
        MSPD_SP_DIRECT,
        MSPD_SP_INDIRECT,
        MSPD_SP_XDATA
    } mspd_space_t;

    typedef struct packed {
        logic        valid;
        mspd_space_t space;
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mspd_dreq_t;

    typedef struct packed {
        logic        valid;
        logic        miss;
        logic [7:0]  rdata;
    } mspd_drsp_t;

    typedef struct packed {
        logic        sel;
        logic        we;
        logic [6:0]  addr;
        logic [7:0]  wdata;
    } mspd_sfr_t;
endpackage

// File: hw/mspd_pager.sv
// Program memory pager, data space decoder and data pointer decrement
`include "mspd_params.svh"
`timescale 1ns/1ps
`default_nettype none
module mspd_pager #(
    parameter int ROM_AW     = 18,
    parameter int PAGE_AW    = 16,
    parameter int XRAM_DEPTH = 8192,
    parameter int SCR_DEPTH  = 256
) (
    input  wire logic                clk_sys_i,
    input  wire logic                rst_i,
    input  wire logic                page_wr_i,
    input  wire logic                page_sel_i,
    input  wire logic [1:0]          tbl_sel_i,
    input  wire logic                xram_en_wr_i,
    input  wire logic                xram_en_i,
    input  wire logic                fetch_req_i,
    input  wire logic [PAGE_AW-1:0]  fetch_pc_i,
    output logic                     fetch_rdy_o,
    output logic                     fetch_vld_o,
    output logic [7:0]               fetch_data_o,
    input  wire logic                tbl_req_i,
    input  wire logic [PAGE_AW-1:0]  tbl_addr_i,
    output logic                     tbl_rdy_o,
    output logic                     tbl_vld_o,
    output logic [7:0]               tbl_data_o,
    output logic                     rom_en_o,
    output logic [ROM_AW-1:0]        rom_addr_o,
    input  wire logic [7:0]          rom_data_i,
    input  wire mspd_pkg::mspd_dreq_t dreq_i,
    output mspd_pkg::mspd_drsp_t     drsp_o,
    output mspd_pkg::mspd_sfr_t      sfr_o,
    input  wire logic [7:0]          sfr_rdata_i,
    input  wire logic                op_vld_i,
    input  wire logic [7:0]          op_i,
    input  wire logic                data_pointer_wr_i,
    input  wire logic [15:0]         data_pointer_wdata_i,
    output logic [15:0]              data_pointer_o,
    output logic                     opcode_page_select_o,
    output logic [1:0]               table_page_select_o,
    output logic                     xram_en_o
);
    // Page selects and RAM enable
    logic        pg_q;
    logic [1:0]  lt_q;
    logic        xen_q;
    // ROM port pipeline
    logic        fetch_go;
    logic        tbl_go;
    logic        fetch_pend_q;
    logic        tbl_pend_q;
    // Data side
    logic [7:0]  xram_mem [XRAM_DEPTH];
    logic [7:0]  scr_mem  [SCR_DEPTH];
    logic        hit_xram;
    logic        hit_scr;
    logic        hit_sfr;
    logic        rd_xram_q;
    logic        rd_scr_q;
    logic        rd_sfr_q;
    logic [7:0]  xram_rd_q;
    logic [7:0]  scr_rd_q;
    logic        rsp_vld_q;
    logic        rsp_miss_q;
    logic [15:0] data_pointer_q;

    // Page select registers, zero from reset
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pg_q <= `MSPD_PG_RST;
            lt_q <= `MSPD_LT_RST;
        end else if (page_wr_i) begin
            pg_q <= page_sel_i;
            lt_q <= tbl_sel_i;
        end
    end

    // External-move RAM enable
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            xen_q <= `MSPD_XEN_RST;
        end else if (xram_en_wr_i) begin
            xen_q <= xram_en_i;
        end
    end

    assign opcode_page_select_o = pg_q;
    assign table_page_select_o  = lt_q;
    assign xram_en_o            = xen_q;

    // Fetch has priority on the shared ROM port
    assign fetch_go    = fetch_req_i;
    assign tbl_go      = tbl_req_i && !fetch_req_i;
    assign fetch_rdy_o = 1'b1;
    assign tbl_rdy_o   = !fetch_req_i;

    // ROM address: fetch in upper half only, table over all pages
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rom_en_o   <= 1'b0;
            rom_addr_o <= '0;
        end else begin
            rom_en_o <= fetch_go || tbl_go;
            if (fetch_go) begin
                rom_addr_o <= {`MSPD_CODE_A17, pg_q, fetch_pc_i};
            end else if (tbl_go) begin
                rom_addr_o <= {lt_q, tbl_addr_i};
            end
        end
    end

    // Track which requester owns the ROM cycle
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            fetch_pend_q <= 1'b0;
            tbl_pend_q   <= 1'b0;
        end else begin
            fetch_pend_q <= fetch_go;
            tbl_pend_q   <= tbl_go;
        end
    end

    // ROM data returned the cycle after the address
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            fetch_vld_o  <= 1'b0;
            tbl_vld_o    <= 1'b0;
            fetch_data_o <= 8'h00;
            tbl_data_o   <= 8'h00;
        end else begin
            fetch_vld_o <= fetch_pend_q;
            tbl_vld_o   <= tbl_pend_q;
            if (fetch_pend_q) begin
                fetch_data_o <= rom_data_i;
            end
            if (tbl_pend_q) begin
                tbl_data_o <= rom_data_i;
            end
        end
    end

    // Data space decode by instruction class and addressing mode
    always_comb begin
        hit_xram = 1'b0;
        hit_scr  = 1'b0;
        hit_sfr  = 1'b0;
        if (!dreq_i.valid) begin
            hit_xram = 1'b0;
        end else if (dreq_i.space == mspd_pkg::MSPD_SP_XDATA) begin
            hit_xram = xen_q && (dreq_i.addr <= `MSPD_XRAM_TOP);
        end else if (dreq_i.space == mspd_pkg::MSPD_SP_INDIRECT) begin
            hit_scr = 1'b1;
        end else if (dreq_i.addr[7:0] >= `MSPD_SFR_BASE) begin
            hit_sfr = 1'b1;
        end else begin
            hit_scr = 1'b1;
        end
    end

    // External-move RAM storage
    always_ff @(posedge clk_sys_i) begin
        if (hit_xram && dreq_i.we) begin
            xram_mem[dreq_i.addr[12:0]] <= dreq_i.wdata;
        end
        xram_rd_q <= xram_mem[dreq_i.addr[12:0]];
    end

    // Scratchpad storage, indexed by the low byte only
    always_ff @(posedge clk_sys_i) begin
        if (hit_scr && dreq_i.we) begin
            scr_mem[dreq_i.addr[7:0]] <= dreq_i.wdata;
        end
        scr_rd_q <= scr_mem[dreq_i.addr[7:0]];
    end

    // Register port towards peripherals
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sfr_o <= '0;
        end else begin
            sfr_o.sel   <= hit_sfr;
            sfr_o.we    <= hit_sfr && dreq_i.we;
            sfr_o.addr  <= dreq_i.addr[6:0];
            sfr_o.wdata <= dreq_i.wdata;
        end
    end

    // Read source and answer timing
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rd_xram_q  <= 1'b0;
            rd_scr_q   <= 1'b0;
            rd_sfr_q   <= 1'b0;
            rsp_vld_q  <= 1'b0;
            rsp_miss_q <= 1'b0;
        end else begin
            rd_xram_q  <= hit_xram;
            rd_scr_q   <= hit_scr;
            rd_sfr_q   <= hit_sfr;
            rsp_vld_q  <= dreq_i.valid;
            rsp_miss_q <= dreq_i.valid && !(hit_xram || hit_scr || hit_sfr);
        end
    end

    // Answer mux, unmapped reads give zero
    always_comb begin
        drsp_o.valid = rsp_vld_q;
        drsp_o.miss  = rsp_miss_q;
        if (rd_xram_q) begin
            drsp_o.rdata = xram_rd_q;
        end else if (rd_scr_q) begin
            drsp_o.rdata = scr_rd_q;
        end else if (rd_sfr_q) begin
            drsp_o.rdata = sfr_rdata_i;
        end else begin
            drsp_o.rdata = 8'h00;
        end
    end

    // Data pointer with load and decrement
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            data_pointer_q <= `MSPD_DATA_POINTER_RST;
        end else if (data_pointer_wr_i) begin
            data_pointer_q <= data_pointer_wdata_i;
        end else if (op_vld_i && op_i == `MSPD_DECREMENT_POINTER_INSTR_OP) begin
            data_pointer_q <= data_pointer_q - `MSPD_DATA_POINTER_STEP;
        end
    end

    assign data_pointer_o = data_pointer_q;

    // Checks
    AST_FETCH_PAGE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        fetch_go |=> rom_addr_o[ROM_AW-2] == $past(pg_q)
            && rom_addr_o[PAGE_AW-1:0] == $past(fetch_pc_i))
        else $error("fetch page or offset wrong");
    AST_FETCH_UPPER: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        fetch_pend_q |-> rom_addr_o[ROM_AW-1] == `MSPD_CODE_A17)
        else $error("fetch outside code region");
    AST_TBL_PAGE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        tbl_go |=> rom_addr_o == {$past(lt_q), $past(tbl_addr_i)})
        else $error("table address wrong");
    AST_ROM_DATA: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        fetch_go |=> ##1 fetch_vld_o && fetch_data_o == $past(rom_data_i))
        else $error("fetch data not returned");
    AST_XRAM_GATE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        hit_xram |-> dreq_i.space == mspd_pkg::MSPD_SP_XDATA
            && dreq_i.addr <= `MSPD_XRAM_TOP)
        else $error("xram hit outside its space");
    AST_XRAM_OFF: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        dreq_i.valid && !xen_q && dreq_i.space == mspd_pkg::MSPD_SP_XDATA
            |=> drsp_o.miss)
        else $error("disabled xram answered");
    AST_SFR_DIRECT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        dreq_i.valid && dreq_i.space == mspd_pkg::MSPD_SP_INDIRECT
            |=> !sfr_o.sel && rd_scr_q)
        else $error("indirect reached registers");
    AST_SFR_RANGE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        sfr_o.sel |-> $past(dreq_i.space) == mspd_pkg::MSPD_SP_DIRECT
            && $past(dreq_i.addr[7]))
        else $error("register select outside 80h-ffh");
    AST_SCR_RW: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        hit_scr && dreq_i.we ##1 dreq_i.valid && hit_scr && !dreq_i.we
            && dreq_i.addr[7:0] == $past(dreq_i.addr[7:0])
            |=> drsp_o.rdata == $past(dreq_i.wdata, 2))
        else $error("scratchpad readback wrong");
    AST_NO_ALIAS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        hit_xram |-> !hit_scr && !hit_sfr)
        else $error("spaces overlap");
    AST_DECREMENT_POINTER_INSTR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        op_vld_i && op_i == `MSPD_DECREMENT_POINTER_INSTR_OP && !data_pointer_wr_i
            |=> data_pointer_o == $past(data_pointer_o) - `MSPD_DATA_POINTER_STEP)
        else $error("pointer not decremented");
    AST_RESET_PAGES: assert property (@(posedge clk_sys_i)
        $fell(rst_i) |-> !pg_q && lt_q == `MSPD_LT_RST)
        else $error("page selects not zero after reset");

    COV_FETCH_PG1: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        fetch_go && pg_q);
    COV_TBL_PG3: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        tbl_go && lt_q == 2'h3);
    COV_XRAM_WR: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        hit_xram && dreq_i.we);
    COV_DEC: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        op_vld_i && op_i == `MSPD_DECREMENT_POINTER_INSTR_OP && data_pointer_o == 16'h0000);
endmodule
`default_nettype wire

// File: tb/mspd_far_model.sv
// Far-side model: program ROM and peripheral register responder
`timescale 1ns/1ps
`default_nettype none
module mspd_far_model (
    input  wire logic                clk_sys_i,
    input  wire logic                rom_en_i,
    input  wire logic [17:0]         rom_addr_i,
    output logic      [7:0]          rom_data_o,
    input  wire mspd_pkg::mspd_sfr_t sfr_i,
    output logic      [7:0]          sfr_rdata_o
);
    logic [7:0] rom_last_q = 8'h00;
    logic [7:0] sfr_last_q = 8'h00;
    // ROM byte mixes page bits into the offset so pages differ
    always_comb begin
        if (rom_en_i) begin
            rom_data_o = rom_addr_i[7:0] ^ {rom_addr_i[17:14], 4'h0};
        end else begin
            rom_data_o = ~rom_last_q; // Idle bus shows no stale byte
        end
    end
    // Peripheral answers with a marker bit and its register index
    always_comb begin
        if (sfr_i.sel) begin
            sfr_rdata_o = {1'b1, sfr_i.addr};
        end else begin
            sfr_rdata_o = ~sfr_last_q;
        end
    end
    // Keep last values so idle lines change every cycle
    always_ff @(posedge clk_sys_i) begin
        rom_last_q <= rom_data_o;
        sfr_last_q <= sfr_rdata_o;
    end
endmodule
`default_nettype wire

// File: tb/mspd_pager_test.sv
// Self-checking bench for the memory space pager and decoder
`timescale 1ns/1ps
`default_nettype none
module mspd_pager_test;
    logic                 clk_sys_i, rst_i, page_wr_i, page_sel_i, xram_en_wr_i, xram_en_i;
    logic [1:0]           tbl_sel_i;
    logic                 fetch_req_i, fetch_rdy_o, fetch_vld_o, tbl_req_i, tbl_rdy_o, tbl_vld_o;
    logic [15:0]          fetch_pc_i, tbl_addr_i, data_pointer_wdata_i, data_pointer_o;
    logic [7:0]           fetch_data_o, tbl_data_o, rom_data_i, sfr_rdata_i, op_i;
    logic                 rom_en_o, op_vld_i, data_pointer_wr_i, opcode_page_select_o, xram_en_o;
    logic [17:0]          rom_addr_o;
    logic [1:0]           table_page_select_o;
    mspd_pkg::mspd_dreq_t dreq_i;
    mspd_pkg::mspd_drsp_t drsp_o;
    mspd_pkg::mspd_sfr_t  sfr_o;
    int                   errors = 0;
    int                   checked = 0;

    mspd_pager u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .page_wr_i(page_wr_i),
        .page_sel_i(page_sel_i), .tbl_sel_i(tbl_sel_i), .xram_en_wr_i(xram_en_wr_i),
        .xram_en_i(xram_en_i), .fetch_req_i(fetch_req_i), .fetch_pc_i(fetch_pc_i),
        .fetch_rdy_o(fetch_rdy_o), .fetch_vld_o(fetch_vld_o), .fetch_data_o(fetch_data_o),
        .tbl_req_i(tbl_req_i), .tbl_addr_i(tbl_addr_i), .tbl_rdy_o(tbl_rdy_o),
        .tbl_vld_o(tbl_vld_o), .tbl_data_o(tbl_data_o), .rom_en_o(rom_en_o),
        .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i), .dreq_i(dreq_i), .drsp_o(drsp_o),
        .sfr_o(sfr_o), .sfr_rdata_i(sfr_rdata_i), .op_vld_i(op_vld_i), .op_i(op_i),
        .data_pointer_wr_i(data_pointer_wr_i), .data_pointer_wdata_i(data_pointer_wdata_i), .data_pointer_o(data_pointer_o),
        .opcode_page_select_o(opcode_page_select_o),
        .table_page_select_o(table_page_select_o), .xram_en_o(xram_en_o));
    mspd_far_model u_far (.clk_sys_i(clk_sys_i), .rom_en_i(rom_en_o), .rom_addr_i(rom_addr_o),
        .rom_data_o(rom_data_i), .sfr_i(sfr_o), .sfr_rdata_o(sfr_rdata_i));

    // Clock of 100 ns period
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    // Expected ROM byte at a full ROM address
    function automatic logic [7:0] rom_byte(input logic [17:0] a);
        return a[7:0] ^ {a[17:14], 4'h0};
    endfunction

    task automatic give_verdict();
        if (errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Load page selects, then confirm the levels
    task automatic set_page(input logic pg, input logic [1:0] lt);
        page_wr_i = 1'b1;
        page_sel_i = pg;
        tbl_sel_i = lt;
        @(negedge clk_sys_i);
        page_wr_i = 1'b0;
        chk(opcode_page_select_o, pg);
        chk(table_page_select_o, lt);
    endtask

    task automatic set_xen(input logic en);
        dreq_i.valid = 1'b0;
        xram_en_wr_i = 1'b1;
        xram_en_i = en;
        @(negedge clk_sys_i);
        xram_en_wr_i = 1'b0;
        chk(xram_en_o, en);
    endtask

    // Opcode fetch through both code pages in the upper half
    task automatic test_fetch();
        logic [17:0] a;
        for (int p = 0; p < 2; p++) begin
            set_page(p[0], 2'h0);
            fetch_req_i = 1'b1;
            fetch_pc_i = 16'hfffe - 16'(p);
            a = {1'b1, p[0], fetch_pc_i};
            chk(fetch_rdy_o, 1'b1);
            @(negedge clk_sys_i);
            fetch_req_i = 1'b0;
            chk(rom_en_o, 1'b1);
            chk(rom_addr_o, a);
            @(negedge clk_sys_i);
            chk(fetch_vld_o, 1'b1);
            chk(fetch_data_o, rom_byte(a));
        end
    endtask

    // Table reads over all four pages, one refused by a fetch
    task automatic test_table();
        logic [17:0] a;
        for (int p = 0; p < 4; p++) begin
            set_page(1'b0, p[1:0]);
            fetch_req_i = (p == 3);
            fetch_pc_i = 16'h0004;
            tbl_req_i = 1'b1;
            tbl_addr_i = 16'h8001 + 16'(p);
            a = {p[1:0], tbl_addr_i};
            #1 chk(tbl_rdy_o, p != 3);
            if (p == 3) begin
                @(negedge clk_sys_i);
                fetch_req_i = 1'b0;
                chk(rom_addr_o, 18'h20004);
            end
            @(negedge clk_sys_i);
            tbl_req_i = 1'b0;
            chk(rom_addr_o, a);
            @(negedge clk_sys_i);
            chk(tbl_vld_o, 1'b1);
            chk(tbl_data_o, rom_byte(a));
        end
    endtask

    // One data access, judged on the following cycle
    task automatic dacc(input mspd_pkg::mspd_space_t sp, input logic we,
                        input logic [15:0] a, input logic [7:0] wd,
                        input logic miss, input logic [7:0] rd, input logic sel);
        dreq_i = '{1'b1, sp, we, a, wd};
        @(negedge clk_sys_i);
        chk(drsp_o.valid, 1'b1);
        chk(drsp_o.miss, miss);
        chk(sfr_o.sel, sel);
        if (sel) begin
            chk(sfr_o.addr, a[6:0]);
            chk(sfr_o.we, we);
            if (we) begin
                chk(sfr_o.wdata, wd);
            end
        end
        if (!we) begin
            chk(drsp_o.rdata, rd);
        end
    endtask

    // Data spaces: external-move RAM, scratchpad and registers
    task automatic test_data();
        dacc(mspd_pkg::MSPD_SP_XDATA, 1'b0, 16'h0005, 8'h00, 1'b1, 8'h00, 1'b0);
        set_xen(1'b1);
        dacc(mspd_pkg::MSPD_SP_XDATA, 1'b1, 16'h1fff, 8'ha5, 1'b0, 8'h00, 1'b0);
        dacc(mspd_pkg::MSPD_SP_XDATA, 1'b0, 16'h1fff, 8'h00, 1'b0, 8'ha5, 1'b0);
        dacc(mspd_pkg::MSPD_SP_XDATA, 1'b0, 16'h2000, 8'h00, 1'b1, 8'h00, 1'b0);
        dacc(mspd_pkg::MSPD_SP_XDATA, 1'b1, 16'h0010, 8'h11, 1'b0, 8'h00, 1'b0);
        dacc(mspd_pkg::MSPD_SP_DIRECT, 1'b1, 16'h0010, 8'h22, 1'b0, 8'h00, 1'b0);
        dacc(mspd_pkg::MSPD_SP_XDATA, 1'b0, 16'h0010, 8'h00, 1'b0, 8'h11, 1'b0);
        dacc(mspd_pkg::MSPD_SP_INDIRECT, 1'b0, 16'h0010, 8'h00, 1'b0, 8'h22, 1'b0);
        set_xen(1'b0);
        dacc(mspd_pkg::MSPD_SP_XDATA, 1'b1, 16'h0010, 8'h77, 1'b1, 8'h00, 1'b0);
        set_xen(1'b1);
        dacc(mspd_pkg::MSPD_SP_XDATA, 1'b0, 16'h0010, 8'h00, 1'b0, 8'h11, 1'b0);
        dacc(mspd_pkg::MSPD_SP_INDIRECT, 1'b1, 16'h0090, 8'h5a, 1'b0, 8'h00, 1'b0);
        dacc(mspd_pkg::MSPD_SP_INDIRECT, 1'b0, 16'h0090, 8'h00, 1'b0, 8'h5a, 1'b0);
        dacc(mspd_pkg::MSPD_SP_DIRECT, 1'b0, 16'h0090, 8'h00, 1'b0, 8'h90, 1'b1);
        dacc(mspd_pkg::MSPD_SP_DIRECT, 1'b1, 16'h0080, 8'h3c, 1'b0, 8'h00, 1'b1);
        dacc(mspd_pkg::MSPD_SP_INDIRECT, 1'b1, 16'h007f, 8'hc3, 1'b0, 8'h00, 1'b0);
        dacc(mspd_pkg::MSPD_SP_DIRECT, 1'b0, 16'h007f, 8'h00, 1'b0, 8'hc3, 1'b0);
        dreq_i.valid = 1'b0;
    endtask

    // Reset in mid-run returns pages, enable and pointer to zero
    task automatic test_reset();
        set_page(1'b1, 2'h3);
        rst_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        rst_i = 1'b0;
        chk(opcode_page_select_o, 1'b0);
        chk(table_page_select_o, 2'h0);
        chk(xram_en_o, 1'b0);
        chk(data_pointer_o, 16'h0000);
    endtask

    // Decrement opcode, wrap, other opcode and load priority
    task automatic test_data_pointer();
        data_pointer_wr_i = 1'b1;
        data_pointer_wdata_i = 16'h0001;
        @(negedge clk_sys_i);
        data_pointer_wr_i = 1'b0;
        op_vld_i = 1'b1;
        op_i = 8'ha5;
        @(negedge clk_sys_i);
        chk(data_pointer_o, 16'h0000);
        @(negedge clk_sys_i);
        chk(data_pointer_o, 16'hffff);
        op_i = 8'ha4;
        @(negedge clk_sys_i);
        chk(data_pointer_o, 16'hffff);
        op_i = 8'ha5;
        data_pointer_wr_i = 1'b1;
        data_pointer_wdata_i = 16'h1234;
        @(negedge clk_sys_i);
        op_vld_i = 1'b0;
        data_pointer_wr_i = 1'b0;
        chk(data_pointer_o, 16'h1234);
    endtask

    // Watchdog cuts a hang short
    initial begin
        repeat (1000) @(posedge clk_sys_i);
        errors++;
        give_verdict();
    end

    // Main sequence
    initial begin
        rst_i = 1'b1;
        {page_wr_i, page_sel_i, tbl_sel_i, xram_en_wr_i, xram_en_i} = '0;
        {fetch_req_i, fetch_pc_i, tbl_req_i, tbl_addr_i} = '0;
        {op_vld_i, op_i, data_pointer_wr_i, data_pointer_wdata_i} = '0;
        dreq_i = '0;
        repeat (2) @(negedge clk_sys_i);
        rst_i = 1'b0;
        chk(opcode_page_select_o, 1'b0);
        chk(table_page_select_o, 2'h0);
        chk(xram_en_o, 1'b0);
        chk(data_pointer_o, 16'h0000);
        test_fetch();
        test_table();
        test_data();
        test_data_pointer();
        test_reset();
        give_verdict();
    end
endmodule
`default_nettype wire
